// file: hw/ivr_pkg.sv
// package for interrupt vector relocation block
package ivr_pkg;
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PC_W        = 12;
    // register address
    localparam logic [3:0]  ADDR_INT_CTRL = 4'h0;
    localparam logic [3:0]  ADDR_STATUS   = 4'h1;
    // field positions
    localparam int unsigned BIT_UNLOCK  = 0;
    localparam int unsigned BIT_SELECT  = 1;
    localparam int unsigned BIT_EXT2    = 5;
    localparam int unsigned BIT_EXT0    = 6;
    localparam int unsigned BIT_EXT1    = 7;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  EXT_MASK    = 8'he0;
    // unlock window in cycles
    localparam logic [2:0]  UNLOCK_CYCLES = 3'h4;
    // boot section start word addresses per boot size fuse code
    localparam logic [11:0] BOOT_BASE_0 = 12'hc00;
    localparam logic [11:0] BOOT_BASE_1 = 12'he00;
    localparam logic [11:0] BOOT_BASE_2 = 12'hf00;
    localparam logic [11:0] BOOT_BASE_3 = 12'hf80;
    localparam logic [11:0] APP_BASE    = 12'h000;
endpackage

// file: hw/ivr_top.sv
// interrupt vector relocation and unlock control
// Overview of operation
// R1: select bit zero puts vector table at flash start
// R2: select bit one puts vector table at boot section start
// R3: boot section start follows the boot size fuses
// R4: software arms unlock, then writes select with unlock zero within four cycles
// R5: interrupts masked from arming until after the instruction after select write
// R6: without select write, mask lasts exactly four cycles
// R7: automatic mask leaves the global interrupt enable flag untouched
// R8: boot vectors plus boot lock bit block interrupts in application code
// R9: application vectors plus application lock bit block interrupts in boot code
// R10: unlock bit self-clears after four cycles or on select write
// R11: register layout: ext enables 7..5, select 1, unlock 0, 4..2 zero
// R12: boot reset fuse programmed starts execution at boot section start
// R13: boot reset fuse unprogrammed starts execution at address zero
// R14: select write while unlock not armed leaves select unchanged
// R15: vector address is table base plus vector index, reset at zero
`timescale 1ns/10ps
module ivr_top
    import ivr_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset,
    // register port
    input  wire logic [ivr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ivr_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [ivr_pkg::DATA_W-1:0] reg_rdata,
    // fuses and lock bits, static
    input  wire logic                 boot_reset_fuse,
    input  wire logic [1:0]           boot_size_fuses,
    input  wire logic                 app_lock_boot_read_bit,
    input  wire logic                 boot_lock_app_read_bit,
    // core side
    input  wire logic                 exec_in_boot,
    input  wire logic                 instr_done,
    input  wire logic [4:0]           vector_index,
    output logic                      irq_block,
    output logic [ivr_pkg::PC_W-1:0]  vector_addr,
    output logic [ivr_pkg::PC_W-1:0]  reset_addr,
    output logic                      vector_table_select,
    output logic [2:0]                ext_irq_enable
);
    import ivr_pkg::*;

    typedef enum logic [2:0] {
        IVR_IDLE  = 3'b001,
        IVR_ARMED = 3'b010,
        IVR_HOLD  = 3'b100
    } ivr_state_e;

    // boot section start from fuse code
    function automatic logic [PC_W-1:0] ivr_boot_base(input logic [1:0] sz);
        case (sz)
            2'h0:    ivr_boot_base = BOOT_BASE_0;
            2'h1:    ivr_boot_base = BOOT_BASE_1;
            2'h2:    ivr_boot_base = BOOT_BASE_2;
            default: ivr_boot_base = BOOT_BASE_3;
        endcase
    endfunction

    ivr_state_e           state_r, state_nxt;
    logic [2:0]           cnt_r, cnt_nxt;
    logic                 sel_r, sel_nxt;
    logic                 unlock_r, unlock_nxt;
    logic [2:0]           ext_r, ext_nxt;
    logic [DATA_W-1:0]    rdata_nxt;
    logic                 block_nxt;
    logic [PC_W-1:0]      vaddr_nxt, raddr_nxt;
    logic                 ctrl_wr;
    logic [PC_W-1:0]      boot_base;

    assign ctrl_wr   = reg_wr && (reg_addr == ADDR_INT_CTRL);
    assign boot_base = ivr_boot_base(boot_size_fuses); // [R3]

    // control register and unlock sequencer next state
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        sel_nxt    = sel_r;
        unlock_nxt = unlock_r;
        ext_nxt    = ext_r;
        case (state_r)
            IVR_IDLE: begin
                if (ctrl_wr && reg_wdata[BIT_UNLOCK]) begin
                    state_nxt  = IVR_ARMED;
                    unlock_nxt = 1'b1;
                    cnt_nxt    = UNLOCK_CYCLES - 3'h1;
                end
            end
            IVR_ARMED: begin
                if (ctrl_wr && !reg_wdata[BIT_UNLOCK]) begin
                    sel_nxt    = reg_wdata[BIT_SELECT]; // [R4]
                    unlock_nxt = 1'b0; // [R10]
                    state_nxt  = IVR_HOLD;
                end else if (cnt_r == 3'h0) begin
                    unlock_nxt = 1'b0; // [R10] [R6]
                    state_nxt  = IVR_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            IVR_HOLD: begin
                // mask stays until the following instruction completes
                if (instr_done) begin
                    state_nxt = IVR_IDLE; // [R5]
                end
            end
            default: begin
                state_nxt  = IVR_IDLE;
                unlock_nxt = 1'b0;
            end
        endcase
        // select changes only through the armed path [R14]
        if (ctrl_wr) begin
            ext_nxt = reg_wdata[BIT_EXT1:BIT_EXT2]; // [R11]
        end
    end

    // registered control state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r  <= IVR_IDLE;
            cnt_r    <= 3'h0;
            sel_r    <= 1'b0;
            unlock_r <= 1'b0;
            ext_r    <= 3'h0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            sel_r    <= sel_nxt;
            unlock_r <= unlock_nxt;
            ext_r    <= ext_nxt;
        end
    end

    // outputs next values
    always_comb begin
        rdata_nxt = CTRL_RESET;
        if (reg_rd && reg_addr == ADDR_INT_CTRL) begin
            rdata_nxt[BIT_EXT1:BIT_EXT2] = ext_r; // [R11]
            rdata_nxt[BIT_SELECT]        = sel_r;
            rdata_nxt[BIT_UNLOCK]        = unlock_r;
        end else if (reg_rd && reg_addr == ADDR_STATUS) begin
            rdata_nxt[2:0] = state_r;
        end
        // mask from the arming write onward, status flag untouched
        block_nxt = (state_nxt != IVR_IDLE); // [R5] [R7]
        if (sel_nxt && app_lock_boot_read_bit && !exec_in_boot) begin
            block_nxt = 1'b1; // [R8]
        end
        if (!sel_nxt && boot_lock_app_read_bit && exec_in_boot) begin
            block_nxt = 1'b1; // [R9]
        end
        vaddr_nxt = (sel_nxt ? boot_base : APP_BASE) // [R1] [R2]
                    + {{(PC_W-5){1'b0}}, vector_index}; // [R15]
        raddr_nxt = boot_reset_fuse ? boot_base : APP_BASE; // [R12] [R13]
    end

    // output registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata           <= CTRL_RESET;
            irq_block           <= 1'b0;
            vector_addr         <= APP_BASE;
            reset_addr          <= APP_BASE;
            vector_table_select <= 1'b0;
            ext_irq_enable      <= 3'h0;
        end else begin
            reg_rdata           <= rdata_nxt;
            irq_block           <= block_nxt;
            vector_addr         <= vaddr_nxt;
            reset_addr          <= raddr_nxt;
            vector_table_select <= sel_nxt;
            ext_irq_enable      <= ext_nxt;
        end
    end
endmodule

// file: sim/ivr_properties.sv
// checker: port properties of the relocation block
`timescale 1ns/10ps
module ivr_properties
    import ivr_pkg::*;
(
    // clock, reset and register port
    input wire logic        mclk, reset, reg_wr, reg_rd,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata, reg_rdata,
    // fuses, locks, core side and outputs
    input wire logic        boot_reset_fuse, app_lock_boot_read_bit, boot_lock_app_read_bit,
    input wire logic        exec_in_boot, irq_block, vector_table_select,
    input wire logic [1:0]  boot_size_fuses,
    input wire logic [11:0] reset_addr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // decoded control writes and lock cases
    wire arm    = reg_wr && reg_addr == ADDR_INT_CTRL && reg_wdata[0];
    wire sel_wr = reg_wr && reg_addr == ADDR_INT_CTRL && !reg_wdata[0];
    wire no_lk  = !app_lock_boot_read_bit && !boot_lock_app_read_bit;
    wire b_blk  = vector_table_select && app_lock_boot_read_bit && !exec_in_boot;
    wire a_blk  = !vector_table_select && boot_lock_app_read_bit && exec_in_boot;
    // unlock window, mask, select and reserved read bits
    a_arm_masks: assert property (arm |=> irq_block) else $error("no mask");
    a_mask_four: assert property (arm && !irq_block && no_lk ##1 (!reg_wr && no_lk)[*4]
        |-> irq_block ##1 !irq_block) else $error("mask length");
    a_select_takes: assert property (arm && !irq_block ##1 sel_wr
        |=> vector_table_select == $past(reg_wdata[1])) else $error("select lost");
    a_select_guard: assert property ($changed(vector_table_select)
        |-> $past(sel_wr) && $past(irq_block)) else $error("select unarmed");
    a_read_zero: assert property (reg_rd |=> reg_rdata[4:2] == 3'h0)
        else $error("reserved bits");
    // lock bits against execution area
    a_lock_boot: assert property (b_blk[*2] |-> irq_block) else $error("app open");
    a_lock_app: assert property (a_blk[*2] |-> irq_block) else $error("boot open");
    // start address after reset
    a_reset_start: assert property (!$past(reset) && $stable(boot_reset_fuse)
        && $stable(boot_size_fuses) |-> (boot_reset_fuse ? boot_size_fuses != 2'h0
        || reset_addr == BOOT_BASE_0 : reset_addr == APP_BASE)) else $error("reset start");
    c_relocate: cover property (arm ##1 sel_wr);
    c_expire: cover property (arm ##5 !irq_block);
    c_locked: cover property (b_blk || a_blk);
endmodule
bind ivr_top ivr_properties i_props (.*);

// file: sim/ivr_core_model.sv
// core model: instruction pacing and vector fetch index
`timescale 1ns/10ps
module ivr_core_model (
    // clock, reset and pace select
    input  wire logic  mclk,
    input  wire logic  reset,
    input  wire logic  slow,
    // instruction done and fetch index
    output logic       instr_done,
    output logic [4:0] vector_index
);
    logic [1:0] cnt_r;
    // done every cycle or every third; index steps every third cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r <= 2'h0;
            instr_done <= 1'b0;
            vector_index <= 5'h00;
        end else begin
            cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
            instr_done <= !slow || cnt_r == 2'h2;
            vector_index <= vector_index + 5'(cnt_r == 2'h2);
        end
    end
endmodule

// file: sim/testbench.sv
// self-checking bench for the relocation block
`timescale 1ns/10ps
module testbench;
    import ivr_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic        boot_reset_fuse = 1'b0, exec_in_boot = 1'b0, sel_m = 1'b0, armed = 1'b0;
    logic        app_lock_boot_read_bit = 1'b0, boot_lock_app_read_bit = 1'b0;
    logic        instr_done, irq_block, vector_table_select;
    logic [1:0]  boot_size_fuses = 2'h0;
    logic [2:0]  ext_m = 3'h0, ext_irq_enable;
    logic [3:0]  reg_addr = 4'h0;
    logic [4:0]  vector_index;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic [8:0]  tup, ptup;
    logic [11:0] vector_addr, reset_addr, base [4] = '{12'hc00, 12'he00, 12'hf00, 12'hf80};
    int          error_cnt = 0, check_count = 0, seed = 72, i, k;
    initial forever #12.5 mclk = ~mclk;
    ivr_top i_dut (.*);
    ivr_core_model i_core (.*);
    // comparison and verdict
    task automatic chk(input logic [11:0] got, exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // register port cycles with the bench model updated at the taking edge
    task automatic wr(input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= ADDR_INT_CTRL;
        reg_wdata <= d;
        @(posedge mclk);
        if (!d[0] && armed) sel_m = d[1];
        armed = d[0];
        ext_m = d[7:5];
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        armed = 1'b0;
        @(negedge mclk);
        chk(12'(reg_rdata), 12'(exp));
        @(posedge mclk);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        armed = 1'b0;
        repeat (n) @(posedge mclk);
    endtask
    // vector address checked once its inputs held for a cycle
    always @(negedge mclk) begin
        tup = {reset, sel_m, boot_size_fuses, vector_index};
        if (tup == ptup && !reset) chk(vector_addr, (sel_m ? base[boot_size_fuses] : 12'h000) + 12'(vector_index));
        ptup = tup;
    end
    // reset, then relocation rounds over all fuse codes
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(ADDR_INT_CTRL, CTRL_RESET);
        rd(4'h7, 8'h00);
        for (k = 0; k < 8; k++) begin
            boot_size_fuses <= k[1:0];
            boot_reset_fuse <= k[2];
            app_lock_boot_read_bit <= 1'b0;
            boot_lock_app_read_bit <= 1'b0;
            slow <= 1'($random(seed));
            wr(8'($random(seed)) & 8'hfe);
            wr({ext_m, 5'h01});
            wr({ext_m, 3'h0, !sel_m, 1'b0});
            idle(1);
            @(negedge mclk);
            for (i = 0; i < 40 && irq_block !== 1'b0; i++) @(negedge mclk);
            if (i == 40) begin
                error_cnt++;
                report_and_stop();
            end
            chk(12'(vector_table_select), 12'(sel_m));
            chk(12'(ext_irq_enable), 12'(ext_m));
            @(posedge mclk);
            wr({ext_m, 5'h01});
            idle(6);
            rd(ADDR_INT_CTRL, {ext_m, 3'h0, sel_m, 1'b0});
            chk(reset_addr, boot_reset_fuse ? base[boot_size_fuses] : 12'h000);
            exec_in_boot <= k[1];
            app_lock_boot_read_bit <= k[2];
            boot_lock_app_read_bit <= 1'b1;
            idle(3);
            @(negedge mclk);
            chk(12'(irq_block), 12'(sel_m ? (k[2] && !k[1]) : k[1]));
            @(posedge mclk);
        end
        report_and_stop();
    end
endmodule
